//--- core/cief_pkg.sv
// package: register map, field positions and timing for the interrupt enable/flag block
package cief_pkg;
    // register byte addresses on the AXI4-Lite slave
    localparam logic [3:0] CIEF_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] CIEF_ADDR_PENABLE = 4'h4;
    localparam logic [3:0] CIEF_ADDR_CONFIG = 4'h8;
    localparam logic [3:0] CIEF_ADDR_STATUS = 4'hC;
    // control register fields
    localparam int CIEF_GLOBAL_EN_BIT = 7;
    localparam int CIEF_PERIPH_EN_BIT = 6;
    localparam int CIEF_T0_EN_BIT = 5;
    localparam int CIEF_EXTIE_BIT = 4;
    localparam int CIEF_PCIE_BIT = 3;
    localparam int CIEF_T0_FLAG_BIT = 2;
    localparam int CIEF_EXTIF_BIT = 1;
    localparam int CIEF_PCIF_BIT = 0;
    // config register: edge select in bit 8, per-pin change enables in bits 7:0
    localparam int CIEF_EDGE_BIT = 8;
    localparam int CIEF_NPINS = 8;
    // reset values
    localparam logic [7:0] CIEF_CONTROL_RST = 8'h00;
    localparam logic [7:0] CIEF_PENABLE_RST = 8'h00;
    localparam logic [8:0] CIEF_CONFIG_RST = 9'h100;
    // instruction cycle: 4 phases, each one clock here
    localparam logic [1:0] CIEF_PHASES = 2'h3;
    localparam logic [1:0] CIEF_PHASE_Q4 = 2'h3;
    // synchronous latency in instruction cycles before the vector
    localparam logic [1:0] CIEF_SYNC_LAT = 2'h3;
    localparam logic [15:0] CIEF_VECTOR = 16'h0004;
    localparam logic [1:0] CIEF_RESP_OKAY = 2'h0;
    localparam logic [1:0] CIEF_RESP_SLVERR = 2'h2;
endpackage

//--- core/cief_sync.sv
// two-flop synchroniser vector for asynchronous pins
`timescale 1ns/1ps
module cief_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    // first stage feeds only the second
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end
    assign q_o = sync_q;
endmodule

//--- core/cief_top.sv
// interrupt enable/flag logic with AXI4-Lite registers and sequencer handshake
// Overview of operation
// - vector three to four cycles after async event, exactly three after sync event
// - latency independent of one- or two-cycle instruction in progress
// - external flag may set anywhere in Q4 through Q1 phases
// - every flag sets on its condition regardless of any enable; here pin-change flag bit 0 sets only for pins with their per-pin enable set
// - global enable bit 7 allows unmasked interrupts, zero blocks all
// - peripheral enable bit 6 gates all peripheral sources
// - bit 5 enables timer 0 overflow interrupt
// - timer 0 overflow flag bit 2 sets on rollover, stays until cleared
// - bit 4 enables external pin interrupt
// - external flag bit 1 sets on event, cleared only by software
// - bit 3 enables pin-change interrupt; per-pin enables must also be set
// - pin-change flag bit 0 set while any enabled pin has changed
// - enable register bits 7..4: serial tx, serial rx, collision, sync port
// - enable register bits 3..0: capcomp 2, capcomp 1, timer 2, timer 1
// - taking interrupt clears global enable, pushes return, loads vector 0004h
// - return from interrupt sets global enable again
// - external edge select 1 means rising edge, 0 means falling
// - any reset clears global enable
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module cief_top
    import cief_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic ext_pin_i,
    input wire logic [CIEF_NPINS-1:0] change_pins_i,
    input wire logic timer0_rollover_i,
    input wire logic [7:0] periph_flags_i,
    input wire logic [7:0] periph_flags2_req_i,
    input wire logic irq_taken_i,
    input wire logic return_from_irq_i,
    output logic irq_request_o,
    output logic irq_vector_o,
    output logic [15:0] vector_addr_o,
    output logic [1:0] phase_o
);
    import cief_pkg::*;
    default clocking cief_cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    logic [7:0] control_q, control_d;
    logic [7:0] penable_q, penable_d;
    logic [8:0] config_q, config_d;
    logic [CIEF_NPINS-1:0] pins_last_q, pins_last_d;
    logic ext_last_q, ext_last_d;
    logic [1:0] phase_q, phase_d;
    logic pend_q, pend_d;
    logic [1:0] lat_q, lat_d;
    logic req_q, req_d;
    logic vec_q, vec_d;
    logic [15:0] vaddr_q, vaddr_d;
    logic ext_s;
    logic [CIEF_NPINS-1:0] pins_s;
    logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
    logic [3:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic wr_go, ext_edge, pc_flag, core_hit, per_hit, any_req, q4, ctl_wr;

    // pins are asynchronous to the core clock
    cief_sync #(.W(CIEF_NPINS + 1)) u_sync (
        .clk_i(clk_i), .reset_i(reset_i),
        .d_i({ext_pin_i, change_pins_i}),
        .q_o({ext_s, pins_s})
    );

    // axi write channel: address and data taken in either order
    always_comb begin
        awr_d = awr_q;
        wr_d = wr_q;
        bv_d = bv_q;
        bresp_d = bresp_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        if (s_axi_awvalid_i && awr_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr_i;
            awr_d = 1'b0;
        end
        if (s_axi_wvalid_i && wr_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata_i;
            wstrb_d = s_axi_wstrb_i;
            wr_d = 1'b0;
        end
        if (wr_go) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bv_d = 1'b1;
            bresp_d = (awaddr_q[3:2] == CIEF_ADDR_STATUS[3:2]) ? CIEF_RESP_SLVERR
                                                              : CIEF_RESP_OKAY;
        end
        if (bv_q && s_axi_bready_i) begin
            bv_d = 1'b0;
            awr_d = 1'b1;
            wr_d = 1'b1;
        end
    end
    assign wr_go = aw_have_q && w_have_q && !bv_q;
    assign ctl_wr = wr_go && wstrb_q[0] && awaddr_q[3:2] == CIEF_ADDR_CONTROL[3:2];

    // axi read channel: one read in flight, data registered
    always_comb begin
        arr_d = arr_q;
        rv_d = rv_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid_i && arr_q) begin
            arr_d = 1'b0;
            rv_d = 1'b1;
            rresp_d = CIEF_RESP_OKAY;
            unique case (s_axi_araddr_i[3:2])
                CIEF_ADDR_CONTROL[3:2]: rdata_d = {24'h000000, control_q};
                CIEF_ADDR_PENABLE[3:2]: rdata_d = {24'h000000, penable_q};
                CIEF_ADDR_CONFIG[3:2]: rdata_d = {23'h000000, config_q};
                CIEF_ADDR_STATUS[3:2]: rdata_d = {26'h0000000, vec_q, req_q, pend_q,
                                                  phase_q, ext_s};
            endcase
        end
        if (rv_q && s_axi_rready_i) begin
            rv_d = 1'b0;
            arr_d = 1'b1;
        end
    end

    // phase counter: Q1..Q4 of each instruction cycle, one clock per phase
    always_comb begin
        phase_d = (phase_q == CIEF_PHASES) ? 2'h0 : phase_q + 2'h1;
    end
    assign q4 = phase_q == CIEF_PHASE_Q4;

    // edge and change detection
    assign ext_edge = config_q[CIEF_EDGE_BIT] ? (ext_s && !ext_last_q)
                                              : (!ext_s && ext_last_q);
    assign pc_flag = |((pins_s ^ pins_last_q) & config_q[CIEF_NPINS-1:0]);

    // register file and flags; hardware set wins over software clear
    always_comb begin
        control_d = control_q;
        penable_d = penable_q;
        config_d = config_q;
        pins_last_d = pins_s;
        ext_last_d = ext_s;
        if (ctl_wr) begin
            control_d[7:1] = wdata_q[7:1];
        end
        if (wr_go && wstrb_q[0] && awaddr_q[3:2] == CIEF_ADDR_PENABLE[3:2]) begin
            penable_d = wdata_q[7:0];
        end
        if (wr_go && awaddr_q[3:2] == CIEF_ADDR_CONFIG[3:2]) begin
            config_d[7:0] = wstrb_q[0] ? wdata_q[7:0] : config_q[7:0];
            config_d[8] = wstrb_q[1] ? wdata_q[8] : config_q[8];
        end
        // change reference holds while a change is pending until software acks
        if (pc_flag && !(ctl_wr && !wdata_q[CIEF_PCIF_BIT])) begin
            pins_last_d = pins_last_q;
        end
        if (timer0_rollover_i) begin
            control_d[CIEF_T0_FLAG_BIT] = 1'b1;
        end
        if (ext_edge) begin
            control_d[CIEF_EXTIF_BIT] = 1'b1;
        end
        control_d[CIEF_PCIF_BIT] = pc_flag;
        if (irq_taken_i) begin
            control_d[CIEF_GLOBAL_EN_BIT] = 1'b0;
        end
        if (return_from_irq_i) begin
            control_d[CIEF_GLOBAL_EN_BIT] = 1'b1;
        end
    end

    // request qualification
    assign core_hit = (control_q[CIEF_T0_EN_BIT] && control_q[CIEF_T0_FLAG_BIT])
                    || (control_q[CIEF_EXTIE_BIT] && control_q[CIEF_EXTIF_BIT])
                    || (control_q[CIEF_PCIE_BIT] && control_q[CIEF_PCIF_BIT]);
    assign per_hit = control_q[CIEF_PERIPH_EN_BIT]
                   && ((|(periph_flags_i & penable_q)) || (|periph_flags2_req_i));
    assign any_req = control_q[CIEF_GLOBAL_EN_BIT] && (core_hit || per_hit);

    // latency: sample at Q4, whole instruction cycles; losing global enable cancels entry
    always_comb begin
        pend_d = pend_q;
        lat_d = lat_q;
        vec_d = 1'b0;
        vaddr_d = vaddr_q;
        req_d = any_req;
        if (!control_q[CIEF_GLOBAL_EN_BIT]) begin
            pend_d = 1'b0;
        end else if (q4) begin
            if (!pend_q && any_req) begin
                pend_d = 1'b1;
                lat_d = 2'h1;
            end else if (pend_q && lat_q == CIEF_SYNC_LAT - 2'h1) begin
                pend_d = 1'b0;
                vec_d = 1'b1;
                vaddr_d = CIEF_VECTOR;
            end else if (pend_q) begin
                lat_d = lat_q + 2'h1;
            end
        end
    end

    // state registers, all loaded with their reset values by reset; global enable cleared
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            control_q <= CIEF_CONTROL_RST;
            penable_q <= CIEF_PENABLE_RST;
            config_q <= CIEF_CONFIG_RST;
            pins_last_q <= '0;
            ext_last_q <= 1'b0;
            phase_q <= 2'h0;
            pend_q <= 1'b0;
            lat_q <= 2'h0;
            req_q <= 1'b0;
            vec_q <= 1'b0;
            vaddr_q <= 16'h0000;
            awr_q <= 1'b1;
            wr_q <= 1'b1;
            bv_q <= 1'b0;
            bresp_q <= CIEF_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            arr_q <= 1'b1;
            rv_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= CIEF_RESP_OKAY;
        end else begin
            control_q <= control_d;
            penable_q <= penable_d;
            config_q <= config_d;
            pins_last_q <= pins_last_d;
            ext_last_q <= ext_last_d;
            phase_q <= phase_d;
            pend_q <= pend_d;
            lat_q <= lat_d;
            req_q <= req_d;
            vec_q <= vec_d;
            vaddr_q <= vaddr_d;
            awr_q <= awr_d;
            wr_q <= wr_d;
            bv_q <= bv_d;
            bresp_q <= bresp_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            arr_q <= arr_d;
            rv_q <= rv_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready_o = awr_q;
    assign s_axi_wready_o = wr_q;
    assign s_axi_bvalid_o = bv_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arr_q;
    assign s_axi_rvalid_o = rv_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
    assign irq_request_o = req_q;
    assign irq_vector_o = vec_q;
    assign vector_addr_o = vaddr_q;
    assign phase_o = phase_q;
    // checks: vector lands nine clocks after arming unless global enable drops first
    sequence s_armed;
        q4 && !pend_q && any_req;
    endsequence
    property p_latency;
        s_armed ##1 control_q[CIEF_GLOBAL_EN_BIT] [*8] |=> vec_q;
    endproperty
    a_latency: assert property (p_latency) else $error("vector not 3 cycles");
    property p_no_early;
        s_armed |-> !vec_q [*8];
    endproperty
    a_no_early: assert property (p_no_early) else $error("vector too early");
    property p_global_gate;
        !control_q[CIEF_GLOBAL_EN_BIT] |=> !req_q;
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("request while disabled");
    property p_periph_gate;
        (!control_q[CIEF_PERIPH_EN_BIT] && !core_hit) |=> !req_q;
    endproperty
    a_periph_gate: assert property (p_periph_gate) else $error("peripheral not gated");
    property p_t0_set;
        timer0_rollover_i |=> control_q[CIEF_T0_FLAG_BIT];
    endproperty
    a_t0_set: assert property (p_t0_set) else $error("timer flag missed");
    property p_ext_hold;
        (control_q[CIEF_EXTIF_BIT] && !ctl_wr) |=> control_q[CIEF_EXTIF_BIT];
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("ext flag lost");
    property p_taken;
        (irq_taken_i && !return_from_irq_i) |=> !control_q[CIEF_GLOBAL_EN_BIT];
    endproperty
    a_taken: assert property (p_taken) else $error("global enable not cleared");
    property p_reti;
        return_from_irq_i |=> control_q[CIEF_GLOBAL_EN_BIT];
    endproperty
    a_reti: assert property (p_reti) else $error("global enable not set on return");
    property p_vec_addr;
        vec_q |-> vaddr_q == CIEF_VECTOR;
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("bad vector");
endmodule

//--- tb/cief_seq_model.sv
// sequencer stand-in: answers each vector pulse with a taken pulse
`timescale 1ns/1ps
module cief_seq_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic irq_vector_i,
    input wire logic slow_i,
    output logic irq_taken_o
);
    logic [2:0] cnt_q, cnt_d;
    logic busy_q, busy_d, taken_d;
    // slow mode holds the take back, so global enable must stay set until it comes
    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        taken_d = 1'h0;
        if (busy_q) begin
            cnt_d = cnt_q - 3'h1;
            if (cnt_q == 3'h0) begin
                busy_d = 1'h0;
                taken_d = 1'h1;
            end
        end else if (irq_vector_i) begin
            taken_d = !slow_i;
            busy_d = slow_i;
            cnt_d = 3'h4;
        end
    end
    // state registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= 3'h0;
            busy_q <= 1'h0;
            irq_taken_o <= 1'h0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            irq_taken_o <= taken_d;
        end
    end
endmodule

//--- tb/tb.sv
// testbench: register access, flags, enables and vector entry of cief_top
`timescale 1ns/1ps
module tb;
    import cief_pkg::*;
    logic clk_i = '0;
    logic reset_i = '1;
    logic [3:0] awaddr = '0, araddr = '0;
    logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic awready, wready, bvalid, arready, rvalid, req, vec, taken;
    logic ret = '0, slow = '0, ext = '0, t0 = '0, got;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] pins = '0, pflags = '0, pflags2 = '0;
    logic [15:0] vaddr;
    logic [1:0] phase;
    int miscompares = 0, check_count = 0, cyc = 0;
    always #4 clk_i = ~clk_i;
    cief_top dut (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .ext_pin_i(ext), .change_pins_i(pins),
        .timer0_rollover_i(t0), .periph_flags_i(pflags), .periph_flags2_req_i(pflags2),
        .irq_taken_i(taken), .return_from_irq_i(ret), .irq_request_o(req),
        .irq_vector_o(vec), .vector_addr_o(vaddr), .phase_o(phase));
    cief_seq_model seq (.clk_i(clk_i), .reset_i(reset_i), .irq_vector_i(vec),
        .slow_i(slow), .irq_taken_o(taken));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // ready and valid are registered, so the negedge value is what the edge sees
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ta, tw, hs;
        awaddr <= a;
        wdata <= d;
        awvalid <= '1;
        wvalid <= '1;
        bready <= '1;
        do begin
            @(negedge clk_i);
            ta = awvalid && awready;
            tw = wvalid && wready;
            hs = bvalid;
            resp = bresp;
            @(posedge clk_i);
            if (ta) awvalid <= '0;
            if (tw) wvalid <= '0;
        end while (!hs);
        bready <= '0;
        @(posedge clk_i);
    endtask
    task automatic rdr(input logic [3:0] a);
        logic ta, hs;
        araddr <= a;
        arvalid <= '1;
        rready <= '1;
        do begin
            @(negedge clk_i);
            ta = arvalid && arready;
            hs = rvalid;
            rd = rdata;
            @(posedge clk_i);
            if (ta) arvalid <= '0;
        end while (!hs);
        rready <= '0;
        @(posedge clk_i);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // bounded wait for the one-cycle vector pulse
    task automatic wvec();
        got = '0;
        for (int i = 0; i < 60 && !got; i++) begin
            @(posedge clk_i);
            #1;
            got = (vec === 1'h1);
        end
    endtask
    task automatic pulse_ret();
        ret <= '1;
        @(posedge clk_i);
        ret <= '0;
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard: the whole sequence needs well under 2000 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= '0;
        @(posedge clk_i);
        rdr(CIEF_ADDR_CONTROL);
        chk("control_rst", rd, 32'h00);
        rdr(CIEF_ADDR_CONFIG);
        chk("config_rst", rd, 32'h100);
        wr(CIEF_ADDR_PENABLE, 32'hA5);
        rdr(CIEF_ADDR_PENABLE);
        chk("penable_rw", rd, 32'hA5);
        wr(CIEF_ADDR_STATUS, 32'hFF);
        chk("status_wr_resp", {30'h0, resp}, 32'h2);
        // timer flag sets with every control register enable off, then drives a full entry
        t0 <= '1;
        @(posedge clk_i);
        t0 <= '0;
        idle(4);
        chk("req_gie_off", {31'h0, req}, 32'h0);
        rdr(CIEF_ADDR_CONTROL);
        chk("t0_flag_masked", rd, 32'h04);
        wr(CIEF_ADDR_CONTROL, 32'hA0);
        rdr(CIEF_ADDR_CONTROL);
        chk("t0_flag_cleared", rd, 32'hA0);
        t0 <= '1;
        @(posedge clk_i);
        t0 <= '0;
        wvec();
        chk("t0_vector", {31'h0, got}, 32'h1);
        chk("vector_addr", {16'h0, vaddr}, 32'h0004);
        idle(2);
        rdr(CIEF_ADDR_CONTROL);
        chk("global_off_flag_held", rd, 32'h24);
        wr(CIEF_ADDR_CONTROL, 32'h20);
        pulse_ret();
        rdr(CIEF_ADDR_CONTROL);
        chk("global_back", rd, 32'hA0);
        chk("req_after_ret", {31'h0, req}, 32'h0);
        // peripheral path: bit order, peripheral gate, then slow take
        wr(CIEF_ADDR_PENABLE, 32'h01);
        pflags <= 8'h80;
        wr(CIEF_ADDR_CONTROL, 32'hC0);
        idle(12);
        chk("periph_unenabled", {31'h0, req}, 32'h0);
        wr(CIEF_ADDR_CONTROL, 32'h80);
        pflags <= 8'h81;
        pflags2 <= 8'h01;
        idle(12);
        chk("periph_gate", {31'h0, req}, 32'h0);
        slow <= '1;
        wr(CIEF_ADDR_CONTROL, 32'hC0);
        wvec();
        chk("periph_vector", {31'h0, got}, 32'h1);
        idle(3);
        rdr(CIEF_ADDR_CONTROL);
        chk("global_until_taken", rd, 32'hC0);
        idle(10);
        pflags <= 8'h00;
        pflags2 <= 8'h00;
        rdr(CIEF_ADDR_CONTROL);
        chk("global_off_slow", rd, 32'h40);
        pulse_ret();
        // external pin: edge select, sticky flag
        ext <= '1;
        idle(12);
        ext <= '0;
        idle(12);
        rdr(CIEF_ADDR_CONTROL);
        chk("ext_rise_sticky", rd, 32'hC2);
        wr(CIEF_ADDR_CONFIG, 32'h000);
        wr(CIEF_ADDR_CONTROL, 32'h00);
        ext <= '1;
        idle(12);
        rdr(CIEF_ADDR_CONTROL);
        chk("ext_rise_ignored", rd, 32'h00);
        ext <= '0;
        idle(12);
        rdr(CIEF_ADDR_CONTROL);
        chk("ext_fall", rd, 32'h02);
        // pin change: only enabled pins count
        wr(CIEF_ADDR_CONFIG, 32'h001);
        wr(CIEF_ADDR_CONTROL, 32'h00);
        pins <= 8'h02;
        idle(12);
        rdr(CIEF_ADDR_CONTROL);
        chk("pc_pin_off", rd, 32'h00);
        pins <= 8'h03;
        idle(12);
        rdr(CIEF_ADDR_CONTROL);
        chk("pc_pin_on", rd, 32'h01);
        slow <= '0;
        wr(CIEF_ADDR_CONTROL, 32'h88);
        pins <= 8'h02;
        wvec();
        chk("pc_vector", {31'h0, got}, 32'h1);
        // reset in mid-run drops gie
        wr(CIEF_ADDR_CONTROL, 32'h80);
        reset_i <= '1;
        @(posedge clk_i);
        reset_i <= '0;
        @(posedge clk_i);
        #1;
        chk("phase_after_reset", {30'h0, phase}, 32'h1);
        rdr(CIEF_ADDR_CONTROL);
        chk("global_reset", rd, 32'h00);
        report_and_stop();
    end
endmodule
